// [src/mem_decode_defs.svh]
// Address map constants for the memory map decoder.
// Assumes inclusion by both ends and the interface; definitions only.
`ifndef MEM_DECODE_DEFS_SVH
`define MEM_DECODE_DEFS_SVH
`define ADDR_W          17
`define DATA_W          16
`define SFR_END         17'h0000F
`define PER8_START      17'h00010
`define PER8_END        17'h000FF
`define PER16_START     17'h00100
`define PER16_END       17'h001FF
`define RAM_START       17'h00200
`define RAM_END_DEF     17'h003FF
`define ROM_START_DEF   17'h1F000
`define ROM_END         17'h1FFFF
`define VEC_WORDS       16
`define VEC_START       17'h1FFE0
`define FETCH_TRAP_END  17'h001FF
`endif

// [src/mem_decode_pkg.sv]
// Types shared by the decoder, its requester and the interface.
// Assumes mem_decode_defs.svh supplies the numbers.
`include "mem_decode_defs.svh"
package mem_decode_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef enum logic [2:0] {
        REG_NONE  = 3'h0,
        REG_SFR   = 3'h1,
        REG_PER8  = 3'h2,
        REG_PER16 = 3'h3,
        REG_RAM   = 3'h4,
        REG_ROM   = 3'h5
    } region_t;
endpackage

// [src/mem_bus_if.sv]
// CPU-to-decoder access channel.
// Assumes both ends share clk and arst_n.
`timescale 1ns/1ps
interface mem_bus_if;
    import mem_decode_pkg::*;
    logic  req;
    logic  we;
    logic  fetch;
    logic  byte_en;
    addr_t addr;
    data_t wdata;
    logic  ack;
    data_t rdata;
    logic  err;
    logic  rst_req;
    modport dev (input req, we, fetch, byte_en, addr, wdata, output ack, rdata, err, rst_req);
    modport cpu (output req, we, fetch, byte_en, addr, wdata, input ack, rdata, err, rst_req);
endinterface

// [src/mem_requester.sv]
// Requester end: turns a user command into one bus access.
// Assumes one command at a time; waits for ack before the next.
`timescale 1ns/1ps
`include "mem_decode_defs.svh"
module mem_requester (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // Bus
    mem_bus_if.cpu                     bus,
    // User side
    input  wire logic                  cmd_valid,
    input  wire logic                  cmd_we,
    input  wire logic                  cmd_fetch,
    input  wire logic                  cmd_byte,
    input  wire mem_decode_pkg::addr_t cmd_addr,
    input  wire mem_decode_pkg::data_t cmd_wdata,
    output logic                       cmd_ready,
    output logic                       rsp_valid,
    output mem_decode_pkg::data_t      rsp_data,
    output logic                       rsp_err,
    output logic                       rsp_rst
);
    import mem_decode_pkg::*;
    logic busy_r;
    // Fetches and words are forced even so a sloppy caller cannot break alignment
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r        <= 1'b0;
            bus.req       <= 1'b0;
            bus.we        <= 1'b0;
            bus.fetch     <= 1'b0;
            bus.byte_en   <= 1'b0;
            bus.addr      <= '0;
            bus.wdata     <= '0;
        end else if (!busy_r && cmd_valid) begin
            busy_r        <= 1'b1;
            bus.req       <= 1'b1;
            bus.we        <= cmd_we & ~cmd_fetch;
            bus.fetch     <= cmd_fetch;
            bus.byte_en   <= cmd_byte & ~cmd_fetch;
            bus.addr      <= (cmd_fetch || !cmd_byte) ? {cmd_addr[`ADDR_W-1:1], 1'b0} : cmd_addr; // RULE1 RULE13
            bus.wdata     <= cmd_wdata;
        end else if (bus.ack) begin
            busy_r        <= 1'b0;
            bus.req       <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            rsp_err   <= 1'b0;
            rsp_rst   <= 1'b0;
        end else begin
            cmd_ready <= !busy_r && !cmd_valid && !bus.ack;
            rsp_valid <= bus.ack;
            rsp_err   <= bus.ack & bus.err;
            rsp_rst   <= bus.ack & bus.rst_req;
            if (bus.ack) begin
                rsp_data <= bus.rdata;
            end
        end
    end
endmodule

// [src/mem_decoder.sv]
// Unified address decoder with byte/word steering and region storage.
// Assumes one outstanding request, held until ack; answer one cycle later.
// RAM end and flash start are parameters; the gap between them answers err.
//
// Behaviour
// RULE1 - CPU fetches only at even addresses
// RULE2 - Byte and word transfers both supported
// RULE3 - Single decoded space of 128 KB
// RULE4 - Flash ends 0x1FFFF, start is parameter
// RULE5 - Vectors in top 16 flash words
// RULE6 - RAM starts 0200h, end is parameter
// RULE7 - 0100-01FFh decode to 16-bit peripherals
// RULE8 - Even-only bytes there, high byte zero
// RULE9 - 010h-0FFh decode to 8-bit peripherals
// RULE10 - Word read of byte peripheral: high undefined
// RULE11 - Word write to byte peripheral: low byte only
// RULE12 - Lowest 16 bytes special registers, byte only
// RULE13 - Words at even addresses, bytes anywhere
// RULE14 - Little-endian: low byte at even address
// RULE15 - Flash and RAM serve fetches and reads
// RULE16 - Fetch below 0200h requests device reset
// RULE17 - Word access ignores address bit zero
`timescale 1ns/1ps
`include "mem_decode_defs.svh"
module mem_decoder #(
    parameter logic [16:0] RAM_END   = `RAM_END_DEF,
    parameter logic [16:0] ROM_START = `ROM_START_DEF
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     arst_n,
    // Bus
    mem_bus_if.dev        bus,
    // Status
    output logic          vec_hit,
    output logic [3:0]    vec_index
);
    import mem_decode_pkg::*;
    localparam int RAM_BYTES = int'(RAM_END) - `RAM_START + 1;
    localparam int ROM_BYTES = `ROM_END - int'(ROM_START) + 1;
    localparam int RAM_AW    = $clog2(RAM_BYTES);
    localparam int ROM_AW    = $clog2(ROM_BYTES);

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    function automatic region_t decode(input addr_t a);
        if (a <= `SFR_END)                                     decode = REG_SFR;   // RULE12
        else if (a >= `PER8_START && a <= `PER8_END)           decode = REG_PER8;  // RULE9
        else if (a >= `PER16_START && a <= `PER16_END)         decode = REG_PER16; // RULE7
        else if (a >= `RAM_START && a <= RAM_END)              decode = REG_RAM;   // RULE6
        else if (a >= ROM_START && a <= `ROM_END)              decode = REG_ROM;   // RULE4 RULE3
        else                                                   decode = REG_NONE;
    endfunction

    // ------------------------------------------------------------
    // Region offsets
    // ------------------------------------------------------------
    // One place for each base subtraction, so reads and writes
    // can never disagree on where a byte lives
    function automatic logic [7:0] per8_off(input addr_t a);
        per8_off = 8'(a - `PER8_START);
    endfunction

    function automatic logic [RAM_AW-1:0] ram_off(input addr_t a);
        ram_off = RAM_AW'(a - `RAM_START);
    endfunction

    function automatic logic [ROM_AW-1:0] rom_off(input addr_t a);
        rom_off = ROM_AW'(a - ROM_START);
    endfunction

    // ------------------------------------------------------------
    // Storage, byte organised
    // ------------------------------------------------------------
    // Flash is writable here only so a bench can preload tables and vectors
    logic [7:0] sfr_mem   [0:15];
    logic [7:0] per8_mem  [0:239];
    logic [7:0] per16_mem [0:255];
    logic [7:0] ram_mem   [0:RAM_BYTES-1];
    logic [7:0] rom_mem   [0:ROM_BYTES-1];

    region_t    reg_s;
    addr_t      wa;
    logic [7:0] lo_b;
    logic [7:0] hi_b;
    logic       bad;
    logic       trap;
    addr_t      wa_hi;
    logic       take;

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    always_comb begin
        reg_s = decode(bus.addr);
        take  = bus.req && !bus.ack;
        wa    = bus.byte_en ? bus.addr : {bus.addr[`ADDR_W-1:1], 1'b0}; // RULE17
        wa_hi = {wa[`ADDR_W-1:1], 1'b1};                                 // RULE14
        trap  = bus.fetch && (bus.addr <= `FETCH_TRAP_END); // RULE16
        // Misuse that the requester should avoid is flagged, not hidden
        bad   = (reg_s == REG_NONE)
              || (reg_s == REG_SFR && !bus.byte_en)                        // RULE12
              || (reg_s == REG_PER16 && bus.byte_en && bus.addr[0]);       // RULE8
    end

    // ------------------------------------------------------------
    // Read steering
    // ------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input region_t r, input addr_t a);
        case (r)
            REG_SFR:   rd_byte = sfr_mem[a[3:0]];
            REG_PER8:  rd_byte = per8_mem[per8_off(a)];
            REG_PER16: rd_byte = per16_mem[a[7:0]];
            REG_RAM:   rd_byte = ram_mem[ram_off(a)];                    // RULE15
            REG_ROM:   rd_byte = rom_mem[rom_off(a)];                    // RULE15
            default:   rd_byte = 8'h00;
        endcase
    endfunction

    // Called at the taking edge, so the answer reflects the memory as it
    // stands then, even when the address did not move since a write
    function automatic data_t steer_read(input region_t r, input addr_t a, input logic be);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = rd_byte(r, a);
        hi = rd_byte(r, {a[`ADDR_W-1:1], 1'b1});                         // RULE14
        if (be) begin                                                    // RULE2
            steer_read = {8'h00, lo};                                    // RULE8
        end else if (r == REG_PER8) begin
            steer_read = {8'h00, lo};                                    // RULE10
        end else begin
            steer_read = {hi, lo};                                       // RULE14
        end
    endfunction

    // ------------------------------------------------------------
    // Writes
    // ------------------------------------------------------------
    always_comb begin
        lo_b = bus.wdata[7:0];
        hi_b = bus.wdata[15:8];
    end

    // Memories carry no reset; control flops below do
    always_ff @(posedge clk) begin
        if (take && bus.we && !bad && !bus.fetch) begin
            case (reg_s)
                REG_SFR:   sfr_mem[wa[3:0]] <= lo_b;
                REG_PER8:  per8_mem[per8_off(wa)] <= lo_b;               // RULE11
                REG_PER16: begin
                    per16_mem[wa[7:0]] <= lo_b;
                    if (!bus.byte_en) per16_mem[wa_hi[7:0]] <= hi_b;
                end
                REG_RAM: begin
                    ram_mem[ram_off(wa)] <= lo_b;                        // RULE14
                    if (!bus.byte_en) ram_mem[ram_off(wa_hi)] <= hi_b;
                end
                REG_ROM: begin
                    rom_mem[rom_off(wa)] <= lo_b;
                    if (!bus.byte_en) rom_mem[rom_off(wa_hi)] <= hi_b;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // One answer per take; err and reset request only ever ride on ack.
    // A low fetch reports the reset request alone, never err as well.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.ack     <= 1'b0;
            bus.err     <= 1'b0;
            bus.rst_req <= 1'b0;
        end else begin
            bus.ack     <= take;
            bus.err     <= take && bad && !trap;
            bus.rst_req <= take && trap;                                 // RULE16
        end
    end

    // Read data holds between answers so a slow requester may take it late;
    // writes and refused accesses answer zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.rdata <= '0;
        end else if (take) begin
            bus.rdata <= (bus.we || trap || bad) ? 16'h0000 : steer_read(reg_s, wa, bus.byte_en);
        end
    end

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    // Flags fetches and reads that land in the vector table
    // Index 15 is the top word, the highest-priority vector
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vec_hit   <= 1'b0;
            vec_index <= 4'h0;
        end else begin
            vec_hit   <= take && !bus.we && (wa >= `VEC_START);          // RULE5
            vec_index <= wa[4:1];                                        // RULE5
        end
    end
endmodule

// [dv/mem_decode_props.sv]
// Bus checker for the decoder and requester pair.
// Assumes hookup beside the bus interface, signals by name.
`timescale 1ns/1ps
`include "mem_decode_defs.svh"
module mem_decode_props (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  arst_n,
    // Bus
    input wire logic                  req,
    input wire logic                  we,
    input wire logic                  fetch,
    input wire logic                  byte_en,
    input wire mem_decode_pkg::addr_t addr,
    input wire mem_decode_pkg::data_t wdata,
    input wire logic                  ack,
    input wire mem_decode_pkg::data_t rdata,
    input wire logic                  err,
    input wire logic                  rst_req
);
    import mem_decode_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // A request is taken on an edge with req high and no ack pending
    wire tk  = req && !ack;
    wire p16 = addr >= `PER16_START && addr <= `PER16_END;
    property p_ans; tk |=> ack ##1 !ack; endproperty
    a_ans: assert property (p_ans) else $error("ack not one cycle after take");
    property p_fev; req && fetch |-> !addr[0]; endproperty
    a_fev: assert property (p_fev) else $error("odd fetch address");
    property p_wev; req && !byte_en |-> !addr[0]; endproperty
    a_wev: assert property (p_wev) else $error("odd word address");
    property p_trap; tk && fetch && addr <= 17'h001FF |=> rst_req && !err && rdata == 16'h0000; endproperty
    a_trap: assert property (p_trap) else $error("low fetch not trapped");
    property p_code; tk && fetch && addr >= 17'h00200 && addr <= 17'h003FF |=> !rst_req && !err; endproperty
    a_code: assert property (p_code) else $error("ram fetch refused");
    property p_sfr; tk && !byte_en && !fetch && addr <= `SFR_END |=> err; endproperty
    a_sfr: assert property (p_sfr) else $error("word to special reg accepted");
    property p_odd; tk && byte_en && addr[0] && p16 |=> err; endproperty
    a_odd: assert property (p_odd) else $error("odd byte in wide periph accepted");
    property p_hi0; tk && byte_en && !we && !fetch && !addr[0] && p16 |=> !err && rdata[15:8] == 8'h00; endproperty
    a_hi0: assert property (p_hi0) else $error("wide periph byte read high not zero");
    property p_p8; tk && !byte_en && addr >= 17'h00010 && addr <= 17'h000FF |=> !err; endproperty
    a_p8: assert property (p_p8) else $error("word to byte periph refused");
    property p_gap; tk && addr > `RAM_END_DEF && addr < `ROM_START_DEF |=> err && !rst_req; endproperty
    a_gap: assert property (p_gap) else $error("unmapped access accepted");
    property p_qual; err || rst_req |-> ack && !(err && rst_req); endproperty
    a_qual: assert property (p_qual) else $error("status without ack");
endmodule

// [dv/memory_map_decode_byte_word_steer_bench.sv]
// Bench for the decoder and requester joined by the bus interface.
// Assumes the decoder's default RAM and ROM bounds.
`timescale 1ns/1ps
module memory_map_decode_byte_word_steer_bench;
    import mem_decode_pkg::*;
    logic        clk, arst_n, cmd_valid, cmd_we, cmd_fetch, cmd_byte;
    logic        cmd_ready, rsp_valid, rsp_err, rsp_rst, vec_hit;
    addr_t       cmd_addr;
    data_t       cmd_wdata, rsp_data;
    logic [3:0]  vec_index;
    logic [17:0] got;
    logic [4:0]  vs;
    int          bad_count = 0;
    int          n_tests = 0;
    mem_bus_if bus ();
    mem_requester mem_requester_inst (.clk(clk), .arst_n(arst_n), .bus(bus.cpu), .cmd_valid(cmd_valid),
        .cmd_we(cmd_we), .cmd_fetch(cmd_fetch), .cmd_byte(cmd_byte), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .rsp_rst(rsp_rst));
    mem_decoder mem_decoder_inst (.clk(clk), .arst_n(arst_n), .bus(bus.dev), .vec_hit(vec_hit), .vec_index(vec_index));
    mem_decode_props mem_decode_props_inst (.clk(clk), .arst_n(arst_n), .req(bus.req), .we(bus.we),
        .fetch(bus.fetch), .byte_en(bus.byte_en), .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack),
        .rdata(bus.rdata), .err(bus.err), .rst_req(bus.rst_req));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(logic [17:0] seen, logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One access; got holds {rst, err, data}, vs the last vector hit
    task automatic acc(logic w, logic f, logic b, addr_t a, data_t d);
        vs = 5'h00;
        for (int i = 0; i < 20 && cmd_ready !== 1'b1; i++) begin
            @(posedge clk); #1;
        end
        if (cmd_ready !== 1'b1) chk({17'h00000, cmd_ready}, 18'h00001);
        {cmd_valid, cmd_we, cmd_fetch, cmd_byte, cmd_addr, cmd_wdata} = {1'b1, w, f, b, a, d};
        @(posedge clk); #1;
        cmd_valid = 1'b0;
        for (int i = 0; i < 20 && rsp_valid !== 1'b1; i++) begin
            @(posedge clk); #1;
            if (vec_hit === 1'b1) vs = {1'b1, vec_index};
        end
        if (rsp_valid !== 1'b1) chk({17'h00000, rsp_valid}, 18'h00001);
        got = {rsp_rst, rsp_err, rsp_data};
    endtask
    task automatic t_ram();
        acc(1, 0, 0, 17'h00200, 16'hA55A);
        acc(0, 0, 1, 17'h00200, 16'h0000); chk(got, 18'h0005A);
        acc(0, 0, 1, 17'h00201, 16'h0000); chk(got, 18'h000A5);
        acc(1, 0, 0, 17'h00202, 16'h1111);
        acc(1, 0, 1, 17'h00203, 16'h003C);
        acc(0, 0, 0, 17'h00202, 16'h0000); chk(got, 18'h03C11);
        acc(0, 0, 0, 17'h00201, 16'h0000); chk(got, 18'h0A55A);
        acc(0, 0, 0, 17'h00400, 16'h0000); chk(got, 18'h10000);
        $display("ram test done");
    endtask
    task automatic t_per();
        acc(1, 0, 0, 17'h00100, 16'h1234);
        acc(0, 0, 1, 17'h00100, 16'h0000); chk(got, 18'h00034);
        acc(0, 0, 1, 17'h00101, 16'h0000); chk(got, 18'h10000);
        acc(1, 0, 1, 17'h00011, 16'h0066);
        acc(1, 0, 0, 17'h00010, 16'hBEEF);
        acc(0, 0, 1, 17'h00010, 16'h0000); chk(got, 18'h000EF);
        acc(0, 0, 1, 17'h00011, 16'h0000); chk(got, 18'h00066);
        acc(0, 0, 0, 17'h00010, 16'h0000); chk({got[17:16], 8'h00, got[7:0]}, 18'h000EF);
        acc(1, 0, 1, 17'h0000F, 16'h005A);
        acc(0, 0, 1, 17'h0000F, 16'h0000); chk(got, 18'h0005A);
        acc(1, 0, 1, 17'h00000, 16'h0011);
        acc(1, 0, 0, 17'h00000, 16'h7777); chk(got[17:16], 2'b01);
        acc(0, 0, 1, 17'h00000, 16'h0000); chk(got, 18'h00011);
        $display("peripheral test done");
    endtask
    task automatic t_fetch();
        acc(0, 1, 0, 17'h00000, 16'h0000); chk(got, 18'h20000);
        acc(0, 1, 0, 17'h001FE, 16'h0000); chk(got, 18'h20000);
        acc(0, 1, 0, 17'h00200, 16'h0000); chk(got, 18'h0A55A);
        acc(1, 0, 0, 17'h1FFFE, 16'hC0DE);
        acc(0, 1, 0, 17'h1FFFE, 16'h0000); chk(got, 18'h0C0DE);
        chk({13'h0000, vs}, 18'h0001F);
        acc(1, 0, 0, 17'h1FFE0, 16'h1357);
        acc(0, 0, 0, 17'h1FFE0, 16'h0000); chk(got, 18'h01357);
        chk({13'h0000, vs}, 18'h00010);
        acc(0, 0, 1, 17'h1FFFF, 16'h0000); chk(got, 18'h000C0);
        acc(0, 0, 0, 17'h1EFFE, 16'h0000); chk(got, 18'h10000);
        $display("fetch test done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {arst_n, cmd_valid, cmd_we, cmd_fetch, cmd_byte, cmd_addr, cmd_wdata} = '0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        t_ram();
        t_per();
        t_fetch();
        final_report();
    end
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule
